// ==== skip_call_pkg.sv ====
// Purpose: Shared constants for the bit-test-skip and call execute block.
// Assumes: 12-bit instruction words, 11-bit program counter, 8-bit data.
// Notes:   Opcode fields are taken from the top four bits of the word.
`default_nettype none

package skip_call_pkg;
    localparam int          INSN_W       = 12;
    localparam int          PC_W         = 11;
    localparam int          DATA_W       = 8;
    localparam int          FADDR_W      = 5;
    localparam int          BSEL_W       = 3;
    localparam int          OPC_HI       = 11;
    localparam int          OPC_LO       = 8;
    localparam int          BSEL_HI      = 7;
    localparam int          BSEL_LO      = 5;
    localparam int          FADDR_HI     = 4;
    localparam int          FADDR_LO     = 0;
    localparam int          IMM_HI       = 7;
    localparam int          IMM_LO       = 0;
    localparam int          PAGE_HI      = 6;
    localparam int          PAGE_LO      = 5;
    localparam int          PC_ZERO_BIT  = 8;
    localparam logic [3:0]  OPC_SKIP_SET = 4'h7;
    localparam logic [3:0]  OPC_CALL     = 4'h9;
    localparam logic [11:0] INSN_NOP     = 12'h000;
    localparam logic [10:0] PC_RESET     = 11'h7ff;
    localparam logic [10:0] PC_ONE       = 11'h001;
    localparam logic        PC_BIT8_CALL = 1'b0;
endpackage

`default_nettype wire

// ==== ret_stack.sv ====
// Purpose: Return address stack, top entry read out of a register.
// Assumes: Single clock, push only driven by the call path.
// Notes:   Depth is two; a push moves the top entry down one level.
`default_nettype none

module ret_stack
    import skip_call_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            nrst,
    input  wire logic            ce,
    input  wire logic            push,
    input  wire logic [PC_W-1:0] push_data,
    output var  logic [PC_W-1:0] top
);
    logic [PC_W-1:0] top_r;
    logic [PC_W-1:0] top_nxt;
    logic [PC_W-1:0] low_r;
    logic [PC_W-1:0] low_nxt;

    always_comb begin
        top_nxt = top_r;
        low_nxt = low_r;
        if (push) begin
            top_nxt = push_data;
            low_nxt = top_r;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            top_r <= '0;
            low_r <= '0;
        end else if (ce) begin
            top_r <= top_nxt;
            low_r <= low_nxt;
        end
    end

    assign top = top_r;
endmodule

`default_nettype wire

// ==== skip_call_exec.sv ====
// Purpose: Executes bit_test_skip_if_set and subroutine call for a 12-bit core.
// Assumes: One instruction cycle per enabled clock; fetch word arrives with the cycle.
// Notes:   Other opcodes pass through as ordinary single-cycle instructions.
//          All state, the flush cycle included, freezes while ce is low.
//          The return stack is pushed on the edge that loads the call target.
`default_nettype none

// Functional notes
// - Opcode 0111 tests bit b of register f.
// - Set bit skips next instruction, else continue.
// - Skip discards prefetched word, runs no-op.
// - Skip test takes one or two cycles.
// - Opcode 1001 is call with 8-bit target.
// - Call pushes program counter plus one.
// - Call loads immediate into low counter bits.
// - Call loads counter bits 10:9 from page bits.
// - Call clears program counter bit 8.
// - Call always takes two cycles, flushing prefetch.
module skip_call_exec
    import skip_call_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              ce,
    input  wire logic [INSN_W-1:0] fetch_word,
    input  wire logic [DATA_W-1:0] reg_rdata,
    input  wire logic [DATA_W-1:0] status_in,
    output logic [FADDR_W-1:0]     reg_addr,
    output logic [PC_W-1:0]        pc,
    output logic [INSN_W-1:0]      exec_word,
    output logic                   flush,
    output logic                   status_we,
    output logic [PC_W-1:0]        stack_top
);
    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_FLUSH = 2'b01
    } exec_state_e;

    exec_state_e           state_r;
    exec_state_e           state_nxt;
    logic [PC_W-1:0]       pc_r;
    logic [PC_W-1:0]       pc_nxt;
    logic [INSN_W-1:0]     exec_r;
    logic [INSN_W-1:0]     exec_nxt;
    logic                  flush_r;
    logic                  flush_nxt;
    logic [FADDR_W-1:0]    raddr_r;
    logic [FADDR_W-1:0]    raddr_nxt;
    logic                  push;
    logic [PC_W-1:0]       push_data;
    logic                  is_skip;
    logic                  is_call;
    logic                  bit_set;

    function automatic logic [3:0] opcode(input logic [INSN_W-1:0] w);
        return w[OPC_HI:OPC_LO];
    endfunction

    // Decode only while running, so the no-op in a flush cycle is never
    // taken for a second skip or call.
    // skip decode.
    assign is_skip = (state_r == ST_RUN) && (opcode(exec_r) == OPC_SKIP_SET);
    assign is_call = (state_r == ST_RUN) && (opcode(exec_r) == OPC_CALL);
    assign bit_set = reg_rdata[exec_r[BSEL_HI:BSEL_LO]];
    assign push      = ce && is_call;
    assign push_data = pc_r + PC_ONE;

    // One pass decides the next instruction cycle. A taken skip or a call
    // replaces the prefetched word with a no-op, so the word that would have
    // run in the second cycle never reaches exec_word.
    always_comb begin
        state_nxt = ST_RUN;
        pc_nxt    = pc_r + PC_ONE;
        exec_nxt  = fetch_word;
        flush_nxt = 1'b0;
        raddr_nxt = fetch_word[FADDR_HI:FADDR_LO];
        unique case (state_r)
            ST_RUN: begin
                if (is_call) begin
                    pc_nxt    = {status_in[PAGE_HI:PAGE_LO], PC_BIT8_CALL, exec_r[IMM_HI:IMM_LO]};
                    exec_nxt  = INSN_NOP;
                    flush_nxt = 1'b1;
                    state_nxt = ST_FLUSH;
                end else if (is_skip && bit_set) begin
                    exec_nxt  = INSN_NOP;
                    flush_nxt = 1'b1;
                    state_nxt = ST_FLUSH;
                end
            end
            ST_FLUSH: begin
                state_nxt = ST_RUN;
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= ST_RUN;
            pc_r    <= PC_RESET;
            exec_r  <= INSN_NOP;
            flush_r <= 1'b0;
            raddr_r <= '0;
        end else if (ce) begin
            state_r <= state_nxt;
            pc_r    <= pc_nxt;
            exec_r  <= exec_nxt;
            flush_r <= flush_nxt;
            raddr_r <= raddr_nxt;
        end
    end

    ret_stack u_stack (
        .clk       (clk),
        .nrst      (nrst),
        .ce        (ce),
        .push      (push),
        .push_data (push_data),
        .top       (stack_top)
    );

    // The register address is captured together with its word, so reg_rdata
    // is already valid in the cycle in which that word executes. Sampling it
    // one cycle later would test the bit of the following instruction.
    assign reg_addr  = raddr_r;
    assign pc        = pc_r;
    assign exec_word = exec_r;
    assign flush     = flush_r;
    // This block owns no flags; the strobe stays low so the flag logic
    // elsewhere never sees a write from these two instructions.
    // no status writes.
    assign status_we = 1'b0;

    sequence s_call_seen;
        ce && is_call;
    endsequence

    sequence s_skip_taken;
        ce && is_skip && bit_set;
    endsequence

    a_call_target: assert property (@(posedge clk) disable iff (!nrst)
        s_call_seen |=> pc[IMM_HI:IMM_LO] == $past(exec_r[IMM_HI:IMM_LO]))
        else $error("call target low bits wrong");
    a_call_page: assert property (@(posedge clk) disable iff (!nrst)
        s_call_seen |=> pc[PC_W-1:PC_W-2] == $past(status_in[PAGE_HI:PAGE_LO]))
        else $error("call page bits wrong");
    a_call_bit8: assert property (@(posedge clk) disable iff (!nrst)
        s_call_seen |=> pc[PC_ZERO_BIT] == PC_BIT8_CALL)
        else $error("call bit 8 not cleared");
    a_call_push: assert property (@(posedge clk) disable iff (!nrst)
        s_call_seen |=> stack_top == $past(pc) + PC_ONE)
        else $error("return address wrong");
    a_call_flush: assert property (@(posedge clk) disable iff (!nrst)
        s_call_seen |=> flush && exec_word == INSN_NOP)
        else $error("call did not flush");
    a_skip_nop: assert property (@(posedge clk) disable iff (!nrst)
        s_skip_taken |=> flush && exec_word == INSN_NOP)
        else $error("skip did not discard word");
    a_skip_clear: assert property (@(posedge clk) disable iff (!nrst)
        (ce && is_skip && !bit_set) |=> !flush && exec_word == $past(fetch_word))
        else $error("untaken skip disturbed flow");
    a_skip_cycles: assert property (@(posedge clk) disable iff (!nrst)
        s_skip_taken ##1 ce |=> !flush)
        else $error("skip took over two cycles");
    a_no_status: assert property (@(posedge clk) disable iff (!nrst)
        (is_skip || is_call) |-> !status_we)
        else $error("status written");

    // Reset is sampled in the ordinary step so that the edge on which reset
    // is released does not start a check against the held reset state.
    sequence s_plain_step;
        nrst && ce && (state_r == ST_RUN) && !is_call && !(is_skip && bit_set);
    endsequence

    // A low clock enable must hold every output.
    a_freeze_core: assert property (@(posedge clk) disable iff (!nrst)
        !ce |=> $stable(pc) && $stable(exec_word) && $stable(flush))
        else $error("core state moved while ce low");
    a_freeze_side: assert property (@(posedge clk) disable iff (!nrst)
        !ce |=> $stable(stack_top) && $stable(reg_addr))
        else $error("stack or address moved while ce low");

    // Ordinary flow and the return from a flush cycle.
    a_step_flow: assert property (@(posedge clk) disable iff (!nrst)
        s_plain_step |=> pc == $past(pc) + PC_ONE && exec_word == $past(fetch_word))
        else $error("ordinary step disturbed");
    a_flush_back: assert property (@(posedge clk) disable iff (!nrst)
        (nrst && ce && state_r == ST_FLUSH) |=> !flush && state_r == ST_RUN && exec_word == $past(fetch_word))
        else $error("flush cycle did not return to run");
    a_flush_nop: assert property (@(posedge clk) disable iff (!nrst)
        flush |-> exec_word == INSN_NOP)
        else $error("flush without no-op");
    a_skip_pc: assert property (@(posedge clk) disable iff (!nrst)
        s_skip_taken |=> pc == $past(pc) + PC_ONE)
        else $error("skipped slot did not advance pc");
    a_call_after: assert property (@(posedge clk) disable iff (!nrst)
        s_call_seen ##1 (nrst && ce) |=> pc == $past(pc) + PC_ONE && !flush)
        else $error("call took other than two cycles");

    // Stack and register address bookkeeping.
    a_stack_hold: assert property (@(posedge clk) disable iff (!nrst)
        (nrst && !(ce && is_call)) |=> $stable(stack_top))
        else $error("stack moved without a call");
    a_raddr_follow: assert property (@(posedge clk) disable iff (!nrst)
        (nrst && ce) |=> reg_addr == $past(fetch_word[FADDR_HI:FADDR_LO]))
        else $error("register address not taken with word");
endmodule

`default_nettype wire

// ==== data_reg_model.sv ====
// Purpose: Data register file seen by the skip and call execute block.
// Assumes: Read data follows the register address with no delay.
// Notes:   Contents are a fixed pattern so the bench can predict every bit.
`default_nettype none

module data_reg_model
    import skip_call_pkg::*;
(
    input  wire logic [FADDR_W-1:0] reg_addr,
    output logic [DATA_W-1:0]       reg_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    // Register f holds its low three address bits above its full address.
    assign reg_rdata = {reg_addr[2:0], reg_addr};
endmodule

`default_nettype wire

// ==== skip_call_exec_tb.sv ====
// Purpose: Self-checking bench for the skip and call execute block.
// Assumes: The fetch path is played by the bench, one word per cycle.
// Notes:   Each scenario judges its own outcome before it returns.
`default_nettype none

module skip_call_exec_tb
    import skip_call_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic              clk;
    logic              nrst;
    logic              ce;
    logic [INSN_W-1:0] fetch_word;
    logic [DATA_W-1:0] reg_rdata;
    logic [DATA_W-1:0] status_in;
    logic [FADDR_W-1:0] reg_addr;
    logic [PC_W-1:0]   pc;
    logic [INSN_W-1:0] exec_word;
    logic              flush;
    logic              status_we;
    logic [PC_W-1:0]   stack_top;
    logic [PC_W-1:0]   p;
    int                n_fail;
    int                tests_run;

    skip_call_exec i_skip_call_exec (.clk(clk), .nrst(nrst), .ce(ce), .fetch_word(fetch_word),
        .reg_rdata(reg_rdata), .status_in(status_in), .reg_addr(reg_addr), .pc(pc),
        .exec_word(exec_word), .flush(flush), .status_we(status_we), .stack_top(stack_top));
    data_reg_model i_data_reg_model (.reg_addr(reg_addr), .reg_rdata(reg_rdata));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic stop_test;
        if (n_fail == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task automatic put(input logic [INSN_W-1:0] w);
        @(posedge clk);
        fetch_word <= w;
    endtask

    task automatic run_skip(input logic [2:0] b, input logic [4:0] f);
        logic [7:0] d;
        d = {f[2:0], f};
        put({OPC_SKIP_SET, b, f});
        put(12'h5aa);
        #1 p = pc;
        chk(reg_addr === f, "skip register address");
        put(12'h0f0);
        #1;
        if (d[b]) begin
            chk(exec_word === INSN_NOP && flush === 1'b1 && pc === p + PC_ONE, "skip not taken");
        end else begin
            chk(exec_word === 12'h5aa && flush === 1'b0 && pc === p + PC_ONE, "skip wrongly taken");
        end
        put(12'h000);
        #1 chk(exec_word === 12'h0f0 && flush === 1'b0 && status_we === 1'b0, "after skip");
    endtask

    task automatic run_call(input logic [1:0] pg, input logic [7:0] k);
        put({OPC_CALL, k});
        status_in <= {1'b0, pg, 5'h15};
        put(12'h111);
        #1 p = pc;
        put(12'h222);
        #1 chk(pc === {pg, PC_BIT8_CALL, k}, "call target");
        chk(stack_top === p + PC_ONE && exec_word === INSN_NOP && flush === 1'b1, "call push");
        put(12'h000);
        #1 chk(exec_word === 12'h222 && flush === 1'b0 && status_we === 1'b0, "after call");
    endtask

    task automatic run_freeze;
        logic [PC_W-1:0] q;
        logic [PC_W-1:0] s;
        put({OPC_SKIP_SET, 3'h1, 5'h03});
        put(12'h5aa);
        ce <= 1'b0;
        #1 q = pc;
        s = stack_top;
        put(12'h0f0);
        put(12'h0f0);
        put(12'h5aa);
        #1 chk(pc === q && exec_word === {OPC_SKIP_SET, 3'h1, 5'h03} && flush === 1'b0 && stack_top === s
            && reg_addr === 5'h03, "state moved while frozen");
        put(12'h5aa);
        ce <= 1'b1;
        put(12'h0f0);
        #1 chk(exec_word === INSN_NOP && flush === 1'b1 && pc === q + PC_ONE, "skip after freeze");
        put(12'h000);
        #1 chk(exec_word === 12'h0f0 && flush === 1'b0, "after frozen skip");
    endtask

    task automatic run_reset;
        put(12'h000);
        nrst <= 1'b0;
        put(12'h000);
        #1 chk(pc === PC_RESET && exec_word === INSN_NOP && flush === 1'b0 && reg_addr === '0 && stack_top === '0,
            "mid-run reset values");
        @(posedge clk);
        nrst <= 1'b1;
    endtask

    initial begin
        #20000;
        n_fail++;
        stop_test;
    end

    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        fetch_word = 12'h000;
        status_in = 8'h00;
        n_fail = 0;
        tests_run = 0;
        repeat (8) @(posedge clk);
        #1 chk(pc === PC_RESET && exec_word === INSN_NOP && flush === 1'b0 && reg_addr === '0 && stack_top === '0,
            "reset values");
        @(posedge clk);
        nrst <= 1'b1;
        run_skip(3'h1, 5'h03);
        run_skip(3'h2, 5'h03);
        run_skip(3'h7, 5'h1f);
        run_skip(3'h0, 5'h00);
        run_call(2'h3, 8'hff);
        run_call(2'h1, 8'h00);
        run_freeze;
        run_reset;
        run_skip(3'h6, 5'h16);
        stop_test;
    end
endmodule

`default_nettype wire
